// ==== inc/rf_status_pkg.sv ====
// Purpose: Shared constants and carrier types for the reader status/framing register bank
// Assumes: 8-bit register data, byte addresses as printed
// Notes: Error flag register offset is not printed; one is chosen here
package rf_status_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ERROR_FLAGS_ADDR = 8'h0A;
    localparam logic [7:0] FIRST_COLLISION_POSITION_ADDR = 8'h0B;
    localparam logic [7:0] TIMER_COUNT_READBACK_ADDR = 8'h0C;
    localparam logic [7:0] CRC_RESULT_LOW_BYTE_ADDR = 8'h0D;
    localparam logic [7:0] CRC_RESULT_HIGH_BYTE_ADDR = 8'h0E;
    localparam logic [7:0] BIT_FRAMING_CONTROL_ADDR = 8'h0F;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int EEPROM_ACCESS_ERROR_BIT = 5;
    localparam int FIFO_OVERFLOW_BIT = 4;
    localparam int CRC_ERROR_BIT = 3;
    localparam int START_OF_FRAME_ERROR_BIT = 2;
    localparam int PARITY_ERROR_BIT = 1;
    localparam int BIT_COLLISION_BIT = 0;
    localparam int RX_ALIGN_LSB = 4;
    localparam int TX_LAST_LSB = 0;
    localparam logic [7:0] FIRST_COLLISION_RESET = 8'h00;
    localparam logic [7:0] BIT_FRAMING_RESET = 8'h00;
    localparam logic [5:0] ERROR_FLAGS_RESET = 6'h00;
    localparam logic [7:0] BIT_FRAMING_WRITE_MASK = 8'h77;

    // Error events from the receiver, FIFO, EEPROM and CRC units
    typedef struct packed {
        logic eeprom_violation;
        logic eeprom_cmd_start;
        logic fifo_write_full;
        logic crc_fail;
        logic sof_bad;
        logic parity_fail;
        logic collision;
    } err_events_t;

    // Collision report from the receiver
    typedef struct packed {
        logic valid;
        logic [7:0] position;
    } coll_report_t;

    // Host register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// ==== src/rf_error_framing_status.sv ====
// Purpose: Error flags, collision position, timer/CRC readback and bit framing registers
// Assumes: Single clock; event inputs are one-cycle pulses from same-domain units
// Notes: Read data is registered; one cycle after req_in.rd the value shows on rdata_out

// ************************************************************
// Register bank
// ************************************************************
// Function
// - Set EEPROM access error on rights violation
// - Clear EEPROM access error at EEPROM command start
// - Set FIFO overflow on write while full
// - Set CRC error when enabled check fails
// - Set framing error on bad start-of-frame
// - Set parity error on parity failure
// - Set collision error on bit collision
// - Clear receive error flags in prepare state
// - Record first collision position, 00h start bit
// - No collision position under 14443 B
// - Timer readback returns current 8-bit count
// - Expose CRC low/high bytes, valid when done
// - Receive alignment selects first stored bit position
// - Clear receive alignment after reception completes
// - Transmit last-bits count, zero means eight
// - Clear last-bits field after transmission
// - Collision position read-only, resets 00h
// - Bit framing resets 00h, bits 7,3 reserved
module rf_error_framing_status
    import rf_status_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire reg_req_t req_in,
    input wire err_events_t events_in,
    input wire logic receive_crc_check_enable_in,
    input wire logic receiver_prepare_state_in,
    input wire logic protocol_14443b_in,
    input wire coll_report_t coll_in,
    input wire logic rx_done_in,
    input wire logic tx_done_in,
    input wire logic [7:0] timer_count_in,
    input wire logic [15:0] crc_result_in,
    input wire logic crc_done_flag_in,
    output logic [7:0] rdata_out,
    output logic [2:0] receive_bit_alignment_out,
    output logic [2:0] transmit_final_byte_bits_out,
    output logic [5:0] error_flags_out
);

    logic [5:0] error_flags_ff;
    logic [7:0] first_collision_position_ff;
    logic coll_seen_ff;
    logic [7:0] bit_framing_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic framing_wr;

    // Sticky flag: set wins over clear so no event is lost
    function automatic logic sticky(input logic cur, input logic set, input logic clr);
        sticky = set | (cur & ~clr);
    endfunction

    assign framing_wr = req_in.wr && (req_in.addr == BIT_FRAMING_CONTROL_ADDR);

    // ************************************************************
    // Error flags
    // ************************************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            error_flags_ff <= ERROR_FLAGS_RESET;
        end else begin
            error_flags_ff[EEPROM_ACCESS_ERROR_BIT] <= sticky(error_flags_ff[EEPROM_ACCESS_ERROR_BIT],
                events_in.eeprom_violation, events_in.eeprom_cmd_start);
            // Nothing in this bank clears overflow; FIFO flush lives elsewhere
            error_flags_ff[FIFO_OVERFLOW_BIT] <= sticky(error_flags_ff[FIFO_OVERFLOW_BIT],
                events_in.fifo_write_full, 1'b0);
            error_flags_ff[CRC_ERROR_BIT] <= sticky(error_flags_ff[CRC_ERROR_BIT],
                events_in.crc_fail & receive_crc_check_enable_in, receiver_prepare_state_in);
            error_flags_ff[START_OF_FRAME_ERROR_BIT] <= sticky(error_flags_ff[START_OF_FRAME_ERROR_BIT],
                events_in.sof_bad, receiver_prepare_state_in);
            error_flags_ff[PARITY_ERROR_BIT] <= sticky(error_flags_ff[PARITY_ERROR_BIT],
                events_in.parity_fail, receiver_prepare_state_in);
            error_flags_ff[BIT_COLLISION_BIT] <= sticky(error_flags_ff[BIT_COLLISION_BIT],
                events_in.collision, receiver_prepare_state_in);
        end
    end

    // ************************************************************
    // First collision position
    // ************************************************************
    // Only the first report per frame is kept; prepare state rearms
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            first_collision_position_ff <= FIRST_COLLISION_RESET;
            coll_seen_ff <= 1'b0;
        end else if (receiver_prepare_state_in) begin
            coll_seen_ff <= 1'b0;
        end else if (coll_in.valid && !coll_seen_ff && !protocol_14443b_in) begin
            first_collision_position_ff <= coll_in.position;
            coll_seen_ff <= 1'b1;
        end
    end

    // ************************************************************
    // Bit framing control
    // ************************************************************
    // Auto clears take priority over a host write in the same cycle
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bit_framing_ff <= BIT_FRAMING_RESET;
        end else begin
            if (framing_wr) begin
                bit_framing_ff <= req_in.wdata & BIT_FRAMING_WRITE_MASK;
            end
            if (rx_done_in) begin
                bit_framing_ff[RX_ALIGN_LSB +: 3] <= 3'h0;
            end
            if (tx_done_in) begin
                bit_framing_ff[TX_LAST_LSB +: 3] <= 3'h0;
            end
        end
    end

    // Alignment and last-bits count steer receiver and transmitter
    assign receive_bit_alignment_out = bit_framing_ff[RX_ALIGN_LSB +: 3];
    assign transmit_final_byte_bits_out = bit_framing_ff[TX_LAST_LSB +: 3];
    assign error_flags_out = error_flags_ff;

    // ************************************************************
    // Read path
    // ************************************************************
    // Unmapped addresses read zero
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (req_in.addr)
            ERROR_FLAGS_ADDR: nxt_rdata = {2'h0, error_flags_ff};
            FIRST_COLLISION_POSITION_ADDR: nxt_rdata = first_collision_position_ff;
            TIMER_COUNT_READBACK_ADDR: nxt_rdata = timer_count_in;
            CRC_RESULT_LOW_BYTE_ADDR: nxt_rdata = crc_result_in[7:0];
            CRC_RESULT_HIGH_BYTE_ADDR: nxt_rdata = crc_result_in[15:8];
            BIT_FRAMING_CONTROL_ADDR: nxt_rdata = bit_framing_ff & BIT_FRAMING_WRITE_MASK;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_ff <= 8'h00;
        end else if (req_in.rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_out = rdata_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_eeprom_err_set: assert property (@(posedge clk_in) disable iff (!rstn_in)
        events_in.eeprom_violation |=> error_flags_out[EEPROM_ACCESS_ERROR_BIT])
        else $error("eeprom error not set");
    a_eeprom_err_clr: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (events_in.eeprom_cmd_start && !events_in.eeprom_violation) |=> !error_flags_out[EEPROM_ACCESS_ERROR_BIT])
        else $error("eeprom error not cleared");
    a_fifo_ovfl_sticky: assert property (@(posedge clk_in) disable iff (!rstn_in)
        events_in.fifo_write_full |=> error_flags_out[FIFO_OVERFLOW_BIT] [*2])
        else $error("overflow flag not sticky");
    a_crc_err_gate: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!error_flags_out[CRC_ERROR_BIT] && events_in.crc_fail && !receive_crc_check_enable_in)
        |=> !error_flags_out[CRC_ERROR_BIT])
        else $error("crc error set while check disabled");
    a_sof_err_set: assert property (@(posedge clk_in) disable iff (!rstn_in)
        events_in.sof_bad |=> error_flags_out[START_OF_FRAME_ERROR_BIT])
        else $error("framing error not set");
    a_rx_flags_prep: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (receiver_prepare_state_in && !events_in.parity_fail && !events_in.collision)
        |=> !error_flags_out[PARITY_ERROR_BIT] && !error_flags_out[BIT_COLLISION_BIT])
        else $error("receive flags not cleared in prepare");
    a_coll_pos_b: assert property (@(posedge clk_in) disable iff (!rstn_in)
        protocol_14443b_in |=> $stable(first_collision_position_ff))
        else $error("collision position changed under type B");
    a_align_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rx_done_in |=> receive_bit_alignment_out == 3'h0)
        else $error("alignment not cleared");
    a_last_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
        tx_done_in |=> transmit_final_byte_bits_out == 3'h0)
        else $error("last bits not cleared");
    a_reserved_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
        req_in.rd && req_in.addr == BIT_FRAMING_CONTROL_ADDR |=> rdata_out[7] == 1'b0 && rdata_out[3] == 1'b0)
        else $error("reserved framing bits not zero");

    // ************************************************************
    // Error flag set and hold checks
    // ************************************************************

    // Parity failure must show one cycle later
    a_parity_err_set: assert property (@(posedge clk_in) disable iff (!rstn_in)
        events_in.parity_fail |=> error_flags_out[PARITY_ERROR_BIT])
        else $error("parity error not set");

    // Collision event must show one cycle later
    a_coll_err_set: assert property (@(posedge clk_in) disable iff (!rstn_in)
        events_in.collision |=> error_flags_out[BIT_COLLISION_BIT])
        else $error("collision error not set");

    // Enabled CRC failure must show one cycle later
    a_crc_err_set: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (events_in.crc_fail && receive_crc_check_enable_in) |=> error_flags_out[CRC_ERROR_BIT])
        else $error("crc error not set");

    // Prepare state also clears the CRC and start-of-frame flags
    a_crc_sof_prep: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (receiver_prepare_state_in && !events_in.crc_fail && !events_in.sof_bad)
        |=> !error_flags_out[CRC_ERROR_BIT] && !error_flags_out[START_OF_FRAME_ERROR_BIT])
        else $error("crc or framing flag not cleared in prepare");

    // Access error stays until an EEPROM command starts
    a_eeprom_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (error_flags_out[EEPROM_ACCESS_ERROR_BIT] && !events_in.eeprom_cmd_start)
        |=> error_flags_out[EEPROM_ACCESS_ERROR_BIT])
        else $error("eeprom error dropped early");

    // Overflow has no clear inside this bank
    a_fifo_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        error_flags_out[FIFO_OVERFLOW_BIT] |=> error_flags_out[FIFO_OVERFLOW_BIT])
        else $error("overflow flag dropped");

    // Receive flags stay until the next prepare state
    a_crc_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (error_flags_out[CRC_ERROR_BIT] && !receiver_prepare_state_in) |=> error_flags_out[CRC_ERROR_BIT])
        else $error("crc error dropped early");

    // Start-of-frame flag held outside prepare
    a_sof_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (error_flags_out[START_OF_FRAME_ERROR_BIT] && !receiver_prepare_state_in)
        |=> error_flags_out[START_OF_FRAME_ERROR_BIT])
        else $error("framing error dropped early");

    // Parity flag held outside prepare
    a_parity_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (error_flags_out[PARITY_ERROR_BIT] && !receiver_prepare_state_in) |=> error_flags_out[PARITY_ERROR_BIT])
        else $error("parity error dropped early");

    // Collision flag held outside prepare
    a_coll_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (error_flags_out[BIT_COLLISION_BIT] && !receiver_prepare_state_in)
        |=> error_flags_out[BIT_COLLISION_BIT])
        else $error("collision error dropped early");

    // ************************************************************
    // Collision position checks
    // ************************************************************

    // First report of a type A frame is taken as it stands
    a_coll_pos_take: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (coll_in.valid && !coll_seen_ff && !protocol_14443b_in && !receiver_prepare_state_in)
        |=> first_collision_position_ff == $past(coll_in.position))
        else $error("collision position not captured");

    // Later reports in the same frame must not overwrite
    a_coll_pos_first: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (coll_seen_ff && !receiver_prepare_state_in) |=> $stable(first_collision_position_ff))
        else $error("collision position overwritten");

    // Prepare state rearms capture for the next frame
    a_coll_pos_rearm: assert property (@(posedge clk_in) disable iff (!rstn_in)
        receiver_prepare_state_in |=> !coll_seen_ff)
        else $error("collision capture not rearmed");

    // Host writes cannot reach the position register
    a_coll_pos_ro: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (req_in.wr && req_in.addr == FIRST_COLLISION_POSITION_ADDR && !coll_in.valid)
        |=> $stable(first_collision_position_ff))
        else $error("collision position written by host");

    // ************************************************************
    // Read path checks
    // ************************************************************

    // Position read returns the stored value
    a_coll_pos_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (req_in.rd && req_in.addr == FIRST_COLLISION_POSITION_ADDR)
        |=> rdata_out == $past(first_collision_position_ff))
        else $error("collision position read mismatch");

    // Timer read is a live sample at the read edge
    a_timer_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (req_in.rd && req_in.addr == TIMER_COUNT_READBACK_ADDR) |=> rdata_out == $past(timer_count_in))
        else $error("timer read mismatch");

    // CRC low byte read
    a_crc_low_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (req_in.rd && req_in.addr == CRC_RESULT_LOW_BYTE_ADDR) |=> rdata_out == $past(crc_result_in[7:0]))
        else $error("crc low byte read mismatch");

    // CRC high byte read; host alone decides if it is meaningful
    a_crc_high_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (req_in.rd && req_in.addr == CRC_RESULT_HIGH_BYTE_ADDR) |=> rdata_out == $past(crc_result_in[15:8]))
        else $error("crc high byte read mismatch");

    // Flag read has its two unused top bits at zero
    a_flags_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (req_in.rd && req_in.addr == ERROR_FLAGS_ADDR) |=> rdata_out == {2'h0, $past(error_flags_ff)})
        else $error("error flags read mismatch");

    // Framing read shows only the writable fields
    a_framing_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (req_in.rd && req_in.addr == BIT_FRAMING_CONTROL_ADDR)
        |=> rdata_out == ($past(bit_framing_ff) & BIT_FRAMING_WRITE_MASK))
        else $error("framing read mismatch");

    // Addresses outside the bank read zero
    a_unmapped_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (req_in.rd && (req_in.addr < ERROR_FLAGS_ADDR || req_in.addr > BIT_FRAMING_CONTROL_ADDR))
        |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");

    // Read data stands until the next read strobe
    a_rdata_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !req_in.rd |=> $stable(rdata_out))
        else $error("read data changed without read");

    // ************************************************************
    // Bit framing checks
    // ************************************************************

    // Written alignment reaches the receiver unless cleared that cycle
    a_align_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (framing_wr && !rx_done_in) |=> receive_bit_alignment_out == $past(req_in.wdata[RX_ALIGN_LSB +: 3]))
        else $error("alignment write lost");

    // Written last-bits count reaches the transmitter
    a_last_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (framing_wr && !tx_done_in)
        |=> transmit_final_byte_bits_out == $past(req_in.wdata[TX_LAST_LSB +: 3]))
        else $error("last bits write lost");

    // Reserved bits can never be stored
    a_framing_resv: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !bit_framing_ff[7] && !bit_framing_ff[3])
        else $error("reserved framing bit stored");

    // Without write or done pulse the register keeps its value
    a_framing_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!framing_wr && !rx_done_in && !tx_done_in) |=> $stable(bit_framing_ff))
        else $error("framing register changed unasked");

endmodule

// ==== test/rf_unit_model.sv ====
// Purpose: Receiver, transmitter and memory units beside the status bank
// Assumes: Outputs change 1 ns after the rising clock edge
// Notes: Collision position is not held once its valid drops
module rf_unit_model
    import rf_status_pkg::*;
(
    input wire logic clk_in,
    output err_events_t events_out,
    output coll_report_t coll_out,
    output logic prepare_out,
    output logic rx_done_out,
    output logic tx_done_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // Stimulus tasks
    // ************************************************************
    initial begin
        events_out = '0;
        coll_out = '0;
        prepare_out = 1'b0;
        rx_done_out = 1'b0;
        tx_done_out = 1'b0;
    end

    // One-cycle event pulse
    task automatic pulse(input err_events_t e);
        @(posedge clk_in) #1 events_out = e;
        @(posedge clk_in) #1 events_out = '0;
    endtask

    // Prepare, two collision reports, then end of reception
    task automatic frame(input logic [7:0] p1, input logic [7:0] p2);
        @(posedge clk_in) #1 prepare_out = 1'b1;
        @(posedge clk_in) #1 prepare_out = 1'b0;
        coll_out = {1'b1, p1};
        @(posedge clk_in) #1 coll_out = {1'b1, p2};
        @(posedge clk_in) #1 coll_out = {1'b0, ~p2}; // Stale value inverted
        rx_done_out = 1'b1;
        @(posedge clk_in) #1 rx_done_out = 1'b0;
    endtask

    // End of transmission
    task automatic tx_end();
        @(posedge clk_in) #1 tx_done_out = 1'b1;
        @(posedge clk_in) #1 tx_done_out = 1'b0;
    endtask
endmodule

// ==== test/rf_error_framing_status_bench.sv ====
// Purpose: Self-checking bench for the status and framing registers
// Assumes: Inputs driven 1 ns after the rising edge
// Notes: CRC low and high bytes compared with crc_done held high
module rf_error_framing_status_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import rf_status_pkg::*;

    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    reg_req_t req = '0;
    logic crc_en = 1'b0;
    logic proto_b = 1'b0;
    logic [7:0] timer = 8'h00;
    logic [15:0] crc = 16'h0000;
    logic crc_done = 1'b0;
    err_events_t ev;
    coll_report_t coll;
    logic prep, rxd, txd;
    logic [7:0] rdata;
    logic [2:0] align, last;
    logic [5:0] flags;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    always #12.5 clk_in = ~clk_in;

    rf_unit_model model (.clk_in(clk_in), .events_out(ev), .coll_out(coll), .prepare_out(prep),
        .rx_done_out(rxd), .tx_done_out(txd));
    rf_error_framing_status dut (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req), .events_in(ev),
        .receive_crc_check_enable_in(crc_en), .receiver_prepare_state_in(prep),
        .protocol_14443b_in(proto_b), .coll_in(coll), .rx_done_in(rxd), .tx_done_in(txd),
        .timer_count_in(timer), .crc_result_in(crc), .crc_done_flag_in(crc_done),
        .rdata_out(rdata), .receive_bit_alignment_out(align),
        .transmit_final_byte_bits_out(last), .error_flags_out(flags));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in) #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_in) #1 req = '0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in) #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_in) #1 req = '0;
        chk(name, exp, rdata);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_framing();
        wr_reg(BIT_FRAMING_CONTROL_ADDR, 8'hFF);
        rd_chk("framing", BIT_FRAMING_CONTROL_ADDR, 8'h77);
        chk("align", 8'h07, {5'h00, align});
        wr_reg(FIRST_COLLISION_POSITION_ADDR, 8'h55);
        rd_chk("first_collision_position ro", FIRST_COLLISION_POSITION_ADDR, 8'h00);
        model.frame(8'h08, 8'h03);
        rd_chk("first_collision_position", FIRST_COLLISION_POSITION_ADDR, 8'h08);
        rd_chk("align clr", BIT_FRAMING_CONTROL_ADDR, 8'h07);
        model.tx_end();
        chk("last clr", 8'h00, {5'h00, last});
        wr_reg(BIT_FRAMING_CONTROL_ADDR, 8'h30);
        chk("last zero", 8'h30, {1'b0, align, 1'b0, last});
        proto_b = 1'b1;
        model.frame(8'h01, 8'h02);
        rd_chk("first_collision_position b", FIRST_COLLISION_POSITION_ADDR, 8'h08);
        proto_b = 1'b0;
        model.frame(8'h00, 8'h05);
        rd_chk("first_collision_position start", FIRST_COLLISION_POSITION_ADDR, 8'h00);
    endtask

    task automatic t_errors();
        logic [5:0] exp;
        exp = 6'h00;
        model.pulse(7'h08);
        chk("crc gated", 8'h00, {2'b00, flags});
        crc_en = 1'b1;
        for (int k = 0; k < 6; k++) begin
            model.pulse(7'(1) << ((k == 5) ? 6 : k));
            exp[k] = 1'b1;
            chk("flags set", {2'b00, exp}, {2'b00, flags});
        end
        rd_chk("flags hold", ERROR_FLAGS_ADDR, 8'h3F);
        model.frame(8'h04, 8'h06);
        rd_chk("prep clr", ERROR_FLAGS_ADDR, 8'h30);
        model.pulse(7'h20);
        rd_chk("eeprom clr", ERROR_FLAGS_ADDR, 8'h10);
    endtask

    task automatic t_readback();
        timer = 8'h5A;
        crc = 16'hA5C3;
        crc_done = 1'b1;
        rd_chk("timer", TIMER_COUNT_READBACK_ADDR, 8'h5A);
        rd_chk("crc low", CRC_RESULT_LOW_BYTE_ADDR, 8'hC3);
        rd_chk("crc high", CRC_RESULT_HIGH_BYTE_ADDR, 8'hA5);
    endtask

    task automatic test_done();
        $display("Checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            test_done();
        end
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        rd_chk("framing rst", BIT_FRAMING_CONTROL_ADDR, 8'h00);
        chk("flags rst", 8'h00, {2'b00, flags});
        t_framing();
        t_errors();
        t_readback();
        test_done();
    end
endmodule
